// ### t2b_consts.vh
// constants for the timer two and baud clock block
// Summary of operation
// - source bit picks prescaled clock or count pin
// - count advances only while run bit set
// - overflow sets flag, one-cycle overflow pulse
// - trigger falling edge captures count when capture
// - reload mode overflow loads count from capture regs
// - trigger falling edge forces reload in reload mode
// - baud selects force reload, tick replaces flag
// - overflow ticks feed port0 rx/tx baud clocks
// - baud mode never sets overflow flag
// - baud mode counts clock/2 or count pin
// - port1 can never use this timer
// - sync mode half duplex, async full duplex
// - received bytes double buffered per port
// - modes 1/3 timer sources, mode 2 /32 or /64
// - fast generator gives 115.2K or 230.4K
// - fast enable bit0 port0, bit1 port1
// - double-rate bits select 230.4K per port
// - trigger edge with enable sets external flag
// - writing one to overflow flag forces request
// - prescale bit picks /12 or /4, ignored in baud
`ifndef T2B_CONSTS_VH
`define T2B_CONSTS_VH
`define T2B_ADDR_POWER      16'h0087
`define T2B_ADDR_CLKCTL     16'h008e
`define T2B_ADDR_P0CTL      16'h0098
`define T2B_ADDR_P0BUF      16'h0099
`define T2B_ADDR_P1CTL      16'h00c0
`define T2B_ADDR_P1BUF      16'h00c1
`define T2B_ADDR_T2CTL      16'h00c8
`define T2B_ADDR_CAPLO      16'h00ca
`define T2B_ADDR_CAPHI      16'h00cb
`define T2B_ADDR_CNTLO      16'h00cc
`define T2B_ADDR_CNTHI      16'h00cd
`define T2B_ADDR_EXTINT     16'h00d8
`define T2B_ADDR_FASTBAUD   16'he608
`define T2B_BIT_OVF         7
`define T2B_BIT_EXT         6
`define T2B_BIT_RXSEL       5
`define T2B_BIT_TXSEL       4
`define T2B_BIT_EXTEN       3
`define T2B_BIT_RUN         2
`define T2B_BIT_SRC         1
`define T2B_BIT_CPRL        0
`define T2B_BIT_PRESCALE    5
`define T2B_BIT_DOUBLE      7
`define T2B_BIT_MODE0_FAST  5
`define T2B_RST_BYTE        8'h00
`define T2B_RST_WORD        16'h0000
`define T2B_FASTBAUD_MASK   8'h03
`define T2B_COUNT_MAX       16'hffff
`define T2B_PRE_LAST        4'hb
`define T2B_PRE_Q_LAST      2'h3
`define T2B_MODE_SYNC       2'h0
`define T2B_MODE_FIXED      2'h2
`define T2B_CLK_HZ          100000000
`define T2B_FAST_BAUD       230400
`define T2B_OVERSAMPLE      16
`endif

// ### t2b_timer.v
// timer two with baud clock selection for two serial ports
`timescale 1ns/10ps
`include "t2b_consts.vh"
module t2b_timer
(
	input  wire        clk,
	input  wire        reset_n,
	input  wire [15:0] addr,
	input  wire [7:0]  wdata,
	input  wire        wr,
	input  wire        rd,
	output reg  [7:0]  rdata,
	input  wire        external_count_pin,
	input  wire        external_trigger_pin,
	input  wire        timer1_overflow,
	input  wire        port0_rx_done,
	input  wire [7:0]  port0_rx_byte,
	input  wire        port1_rx_done,
	input  wire [7:0]  port1_rx_byte,
	output reg         overflow_pulse_pin,
	output reg         timer_irq,
	output reg  [1:0]  port_rx_tick,
	output reg  [1:0]  port_tx_tick,
	output reg  [1:0]  port_half_duplex,
	output reg  [1:0]  port_rx_overrun
);

	// fast generator phase step at 16x the 230.4K rate
	localparam [63:0] FAST_STEP_W = ((64'd1 << 32) * `T2B_FAST_BAUD * `T2B_OVERSAMPLE)
		/ `T2B_CLK_HZ;
	localparam [31:0] FAST_STEP = FAST_STEP_W[31:0];

	reg  [7:0]  t2ctl;
	reg  [7:0]  clkctl;
	reg  [7:0]  power;
	reg  [7:0]  extint;
	reg  [1:0]  fastbaud;
	reg  [7:0]  portctl [0:1];
	reg  [7:0]  rxbuf [0:1];
	reg  [1:0]  rxfull;
	reg  [15:0] count;
	reg  [15:0] capture;
	reg  [3:0]  pre;
	reg  [5:0]  fixdiv;
	reg  [31:0] fast_acc;
	reg         fast_half;
	reg         count_pin_q;
	reg         trig_pin_q;

	wire       baud_mode = t2ctl[`T2B_BIT_RXSEL] | t2ctl[`T2B_BIT_TXSEL];
	wire       run       = t2ctl[`T2B_BIT_RUN];
	wire       ext_src   = t2ctl[`T2B_BIT_SRC];
	wire       count_fall = count_pin_q & ~external_count_pin;
	wire       trig_fall  = trig_pin_q & ~external_trigger_pin;
	wire       trig_event = trig_fall & t2ctl[`T2B_BIT_EXTEN];
	wire       pre_div12  = (pre == `T2B_PRE_LAST);
	wire       pre_div4   = (pre[1:0] == `T2B_PRE_Q_LAST);
	wire       pre_div2   = pre[0];
	wire [32:0] fast_sum  = {1'b0, fast_acc} + {1'b0, FAST_STEP};
	wire       fast_tick_hi = fast_sum[32];
	wire       fast_tick_lo = fast_sum[32] & fast_half;

	reg        step;
	reg        ovf;
	reg        t2_tick;
	reg        wr_t2ctl;
	reg [7:0]  next_t2ctl;
	reg [15:0] next_count;
	reg [15:0] next_capture;

	always @*
	begin
		// prescaler choice, source choice, run gating
		if (ext_src)
			step = run & count_fall;
		else if (baud_mode)
			step = run & pre_div2;
		else if (clkctl[`T2B_BIT_PRESCALE])
			step = run & pre_div4;
		else
			step = run & pre_div12;
		ovf = step & (count == `T2B_COUNT_MAX);
		t2_tick = ovf & baud_mode;
		next_count = count;
		next_capture = capture;
		if (step)
			next_count = count + 16'h0001;
		if (ovf & (baud_mode | ~t2ctl[`T2B_BIT_CPRL]))
			next_count = capture;
		if (trig_event & ~baud_mode & t2ctl[`T2B_BIT_CPRL])
			next_capture = count;
		if (trig_event & ~baud_mode & ~t2ctl[`T2B_BIT_CPRL])
			next_count = capture;
		if (wr & (addr == `T2B_ADDR_CNTLO))
			next_count = {next_count[15:8], wdata};
		if (wr & (addr == `T2B_ADDR_CNTHI))
			next_count = {wdata, next_count[7:0]};
		if (wr & (addr == `T2B_ADDR_CAPLO))
			next_capture = {next_capture[15:8], wdata};
		if (wr & (addr == `T2B_ADDR_CAPHI))
			next_capture = {wdata, next_capture[7:0]};
		wr_t2ctl = wr & (addr == `T2B_ADDR_T2CTL);
		next_t2ctl = wr_t2ctl ? wdata : t2ctl;
		// hardware set wins over a software clear in the same cycle
		if (ovf & ~baud_mode)
			next_t2ctl[`T2B_BIT_OVF] = 1'b1;
		if (trig_event)
			next_t2ctl[`T2B_BIT_EXT] = 1'b1;
	end

	always @(posedge clk)
	begin
		if (!reset_n)
		begin
			t2ctl <= `T2B_RST_BYTE;
			clkctl <= `T2B_RST_BYTE;
			power <= `T2B_RST_BYTE;
			extint <= `T2B_RST_BYTE;
			fastbaud <= 2'h0;
			count <= `T2B_RST_WORD;
			capture <= `T2B_RST_WORD;
			pre <= 4'h0;
			fixdiv <= 6'h00;
			fast_acc <= 32'h0000_0000;
			fast_half <= 1'b0;
			count_pin_q <= 1'b1;
			trig_pin_q <= 1'b1;
			overflow_pulse_pin <= 1'b0;
			timer_irq <= 1'b0;
			rdata <= `T2B_RST_BYTE;
		end
		else
		begin
			count_pin_q <= external_count_pin;
			trig_pin_q <= external_trigger_pin;
			pre <= pre_div12 ? 4'h0 : pre + 4'h1;
			fixdiv <= fixdiv + 6'h01;
			fast_acc <= fast_sum[31:0];
			if (fast_tick_hi)
				fast_half <= ~fast_half;
			t2ctl <= next_t2ctl;
			count <= next_count;
			capture <= next_capture;
			overflow_pulse_pin <= ovf & ~baud_mode;
			// a written one raises the request just as hardware would
			timer_irq <= next_t2ctl[`T2B_BIT_OVF] | next_t2ctl[`T2B_BIT_EXT];
			if (wr & (addr == `T2B_ADDR_CLKCTL))
				clkctl <= wdata;
			if (wr & (addr == `T2B_ADDR_POWER))
				power <= wdata;
			if (wr & (addr == `T2B_ADDR_EXTINT))
				extint <= wdata;
			if (wr & (addr == `T2B_ADDR_FASTBAUD))
				fastbaud <= wdata[1:0];
			rdata <= `T2B_RST_BYTE;
			if (rd)
			begin
				case (addr)
					`T2B_ADDR_T2CTL:    rdata <= t2ctl;
					`T2B_ADDR_CAPLO:    rdata <= capture[7:0];
					`T2B_ADDR_CAPHI:    rdata <= capture[15:8];
					`T2B_ADDR_CNTLO:    rdata <= count[7:0];
					`T2B_ADDR_CNTHI:    rdata <= count[15:8];
					`T2B_ADDR_CLKCTL:   rdata <= clkctl;
					`T2B_ADDR_POWER:    rdata <= power;
					`T2B_ADDR_EXTINT:   rdata <= extint;
					`T2B_ADDR_FASTBAUD: rdata <= {6'h00, fastbaud} & `T2B_FASTBAUD_MASK;
					`T2B_ADDR_P0CTL:    rdata <= portctl[0];
					`T2B_ADDR_P1CTL:    rdata <= portctl[1];
					`T2B_ADDR_P0BUF:    rdata <= rxbuf[0];
					`T2B_ADDR_P1BUF:    rdata <= rxbuf[1];
					default:            rdata <= `T2B_RST_BYTE;
				endcase
			end
		end
	end

	// per-port baud clock selection, receive holding buffer
	genvar p;
	generate
		for (p = 0; p < 2; p = p + 1)
		begin : g_port
			wire [15:0] ctl_addr = p ? `T2B_ADDR_P1CTL : `T2B_ADDR_P0CTL;
			wire [15:0] buf_addr = p ? `T2B_ADDR_P1BUF : `T2B_ADDR_P0BUF;
			wire        rx_done  = p ? port1_rx_done : port0_rx_done;
			wire [7:0]  rx_byte  = p ? port1_rx_byte : port0_rx_byte;
			wire        dbl      = p ? extint[`T2B_BIT_DOUBLE] : power[`T2B_BIT_DOUBLE];
			wire [1:0]  mode     = {portctl[p][7], portctl[p][6]};
			// port1 has no path to this timer at all
			wire        use_rx_t2 = (p == 0) & t2ctl[`T2B_BIT_RXSEL];
			wire        use_tx_t2 = (p == 0) & t2ctl[`T2B_BIT_TXSEL];
			wire        fast_tick = dbl ? fast_tick_hi : fast_tick_lo;
			reg         var_rx;
			reg         var_tx;
			reg         base;
			always @*
			begin
				// timer1 still routed if firmware breaks the source pairing
				if (fastbaud[p])
				begin
					var_rx = fast_tick;
					var_tx = fast_tick;
				end
				else
				begin
					var_rx = use_rx_t2 ? t2_tick : timer1_overflow;
					var_tx = use_tx_t2 ? t2_tick : timer1_overflow;
				end
				case (mode)
					`T2B_MODE_SYNC:
						base = portctl[p][`T2B_BIT_MODE0_FAST] ? pre_div4 : pre_div12;
					`T2B_MODE_FIXED:
						base = dbl ? (fixdiv[4:0] == 5'h1f) : (fixdiv == 6'h3f);
					default:
						base = 1'b0;
				endcase
			end
			always @(posedge clk)
			begin
				if (!reset_n)
				begin
					portctl[p] <= `T2B_RST_BYTE;
					rxbuf[p] <= `T2B_RST_BYTE;
					rxfull[p] <= 1'b0;
					port_rx_tick[p] <= 1'b0;
					port_tx_tick[p] <= 1'b0;
					port_half_duplex[p] <= 1'b0;
					port_rx_overrun[p] <= 1'b0;
				end
				else
				begin
					if (wr & (addr == ctl_addr))
						portctl[p] <= wdata;
					port_half_duplex[p] <= (mode == `T2B_MODE_SYNC);
					port_rx_tick[p] <= (mode[0] ? var_rx : base);
					port_tx_tick[p] <= (mode[0] ? var_tx : base);
					// shifter keeps filling while the held byte is read
					if (rx_done)
						rxbuf[p] <= rx_byte;
					if (rx_done)
						rxfull[p] <= 1'b1;
					else if (rd & (addr == buf_addr))
						rxfull[p] <= 1'b0;
					port_rx_overrun[p] <= rx_done & rxfull[p] & ~(rd & (addr == buf_addr));
				end
			end
		end
	endgenerate

endmodule

// ### t2b_timer_props.sv
// port assertions for the timer two block
`timescale 1ns/10ps
module t2b_timer_props
(
	input wire        clk,
	input wire        reset_n,
	input wire [15:0] addr,
	input wire [7:0]  wdata,
	input wire        wr,
	input wire        rd,
	input wire [7:0]  rdata,
	input wire        overflow_pulse_pin,
	input wire        timer_irq,
	input wire [1:0]  port_rx_tick,
	input wire [1:0]  port_tx_tick,
	input wire [1:0]  port_half_duplex
);
	// ctl shadow holds the whole written byte, p0sync only the port0 mode test; hardware flag sets are not tracked
	reg [7:0] ctl;
	reg       p0sync;
	wire      baud = ctl[5] | ctl[4];
	always @(posedge clk)
	begin
		if (!reset_n)
			ctl <= 8'h00;
		else if (wr && addr == 16'h00c8)
			ctl <= wdata;
	end
	always @(posedge clk)
	begin
		if (!reset_n)
			p0sync <= 1'b1;
		else if (wr && addr == 16'h0098)
			p0sync <= (wdata[7:6] == 2'h0);
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	pulse_one_cycle_a: assert property (overflow_pulse_pin |=> !overflow_pulse_pin)
		else $error("overflow pulse longer than one cycle");
	irq_follows_a: assert property (overflow_pulse_pin |-> ##[0:1] timer_irq)
		else $error("overflow without interrupt request");
	baud_no_pulse_a: assert property (baud && $past(baud) |-> !overflow_pulse_pin)
		else $error("overflow pulse in baud mode");
	stopped_quiet_a: assert property (!ctl[2] && $past(!ctl[2]) |-> !overflow_pulse_pin)
		else $error("overflow pulse while stopped");
	rx_tick_one_a: assert property (port_rx_tick[0] |=> !port_rx_tick[0])
		else $error("receive tick longer than one cycle");
	tx_tick_one_a: assert property (port_tx_tick[0] |=> !port_tx_tick[0])
		else $error("transmit tick longer than one cycle");
	half_duplex_a: assert property ($past(reset_n) |-> port_half_duplex[0] == $past(p0sync))
		else $error("half duplex flag disagrees with mode");
	fast_reserved_a: assert property ($past(rd && addr == 16'he608) |-> rdata[7:2] == 6'h00)
		else $error("reserved fast baud bits not zero");
endmodule
bind t2b_timer t2b_timer_props t2b_timer_props_i (.clk, .reset_n, .addr, .wdata, .wr, .rd,
	.rdata, .overflow_pulse_pin, .timer_irq, .port_rx_tick, .port_tx_tick, .port_half_duplex);

// ### t2b_serial_far.sv
// far side model: receive shifter, timer one and count pin source
`timescale 1ns/10ps
module t2b_serial_far
(
	input  wire       clk,
	input  wire       reset_n,
	input  wire       send,
	input  wire [7:0] byte_in,
	output reg        rx_done,
	output reg  [7:0] rx_byte,
	output reg        t1_ovf,
	output reg        count_pin
);
	reg [5:0] div;
	always @(posedge clk)
	begin
		if (!reset_n)
			div <= 6'h00;
		else
			div <= (div == 6'h31) ? 6'h00 : div + 6'h01;
		t1_ovf <= reset_n && div == 6'h31;
		count_pin <= div[4]; // slow enough for the count input
		rx_done <= reset_n && send;
		// byte only valid with done, otherwise it churns
		rx_byte <= send ? byte_in : ~rx_byte;
	end
endmodule

// ### test_t2b_timer.sv
// self-checking bench for the timer two block
`timescale 1ns/10ps
`include "t2b_consts.vh"
module test_t2b_timer;
	reg         clk, reset_n, wr, rd, trig, send;
	reg  [15:0] addr;
	reg  [7:0]  wdata, sbyte;
	wire [7:0]  rdata, rxb;
	wire        ovp, irq, rxd, t1o, cpin;
	wire [1:0]  rxt, txt, hdx;
	integer     fail_count, n_compared, i;
	t2b_timer t2b_timer_i (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .external_count_pin(cpin), .external_trigger_pin(trig),
		.timer1_overflow(t1o), .port0_rx_done(rxd), .port0_rx_byte(rxb), .port1_rx_done(1'b0),
		.port1_rx_byte(8'h00), .overflow_pulse_pin(ovp), .timer_irq(irq), .port_rx_tick(rxt),
		.port_tx_tick(txt), .port_half_duplex(hdx), .port_rx_overrun());
	t2b_serial_far t2b_serial_far_i (.clk(clk), .reset_n(reset_n), .send(send),
		.byte_in(sbyte), .rx_done(rxd), .rx_byte(rxb), .t1_ovf(t1o), .count_pin(cpin));
	task chk(input [15:0] what, input [7:0] e, input [7:0] g);
	begin
		n_compared = n_compared + 1;
		if (g !== e)
		begin
			fail_count = fail_count + 1;
			$display("MISMATCH item %h expected %h seen %h", what, e, g);
		end
	end
	endtask
	task wreg(input [15:0] a, input [7:0] d);
	begin
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	end
	endtask
	task rchk(input [15:0] a, input [7:0] e);
	begin
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(a, e, rdata);
	end
	endtask
	task tally_and_finish;
	begin
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	end
	endtask
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial
	begin
		#200000;
		fail_count = fail_count + 1;
		tally_and_finish;
	end
	initial
	begin
		{reset_n, wr, rd, send, addr, wdata, sbyte} = 0;
		trig = 1'b1;
		fail_count = 0;
		n_compared = 0;
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
		rchk(`T2B_ADDR_T2CTL, 8'h00);
		rchk(16'h0001, 8'h00);
		wreg(`T2B_ADDR_FASTBAUD, 8'hff);
		rchk(`T2B_ADDR_FASTBAUD, 8'h03);
		chk(16'h0f05, 8'h03, {6'h0, hdx});
		wreg(`T2B_ADDR_FASTBAUD, 8'h00);
		wreg(`T2B_ADDR_CLKCTL, 8'h20);
		wreg(`T2B_ADDR_CAPLO, 8'hfe);
		wreg(`T2B_ADDR_CAPHI, 8'hff);
		wreg(`T2B_ADDR_CNTLO, 8'hff);
		wreg(`T2B_ADDR_CNTHI, 8'hff);
		wreg(`T2B_ADDR_T2CTL, 8'h04);
		for (i = 0; i < 40 && ovp !== 1'b1; i = i + 1)
			@(posedge clk) #1;
		chk(16'h0f01, 8'h01, {7'h0, ovp});
		chk(16'h0f04, 8'h01, {7'h0, irq});
		rchk(`T2B_ADDR_T2CTL, 8'h84);
		wreg(`T2B_ADDR_T2CTL, 8'h00);
		rchk(`T2B_ADDR_CNTHI, 8'hff);
		wreg(`T2B_ADDR_T2CTL, 8'h80);
		@(posedge clk) #1;
		chk(16'h0f06, 8'h01, {7'h0, irq});
		wreg(`T2B_ADDR_T2CTL, 8'h00);
		@(posedge clk) #1;
		chk(16'h0f07, 8'h00, {7'h0, irq});
		wreg(`T2B_ADDR_CNTLO, 8'h34);
		repeat (30) @(posedge clk);
		rchk(`T2B_ADDR_CNTLO, 8'h34);
		wreg(`T2B_ADDR_CNTHI, 8'h12);
		wreg(`T2B_ADDR_T2CTL, 8'h09);
		trig <= 1'b0;
		repeat (3) @(posedge clk);
		rchk(`T2B_ADDR_CAPLO, 8'h34);
		rchk(`T2B_ADDR_CAPHI, 8'h12);
		rchk(`T2B_ADDR_T2CTL, 8'h49);
		wreg(`T2B_ADDR_T2CTL, 8'h08);
		wreg(`T2B_ADDR_CNTLO, 8'h00);
		trig <= 1'b1;
		repeat (3) @(posedge clk);
		trig <= 1'b0;
		repeat (3) @(posedge clk);
		rchk(`T2B_ADDR_CNTLO, 8'h34);
		rchk(`T2B_ADDR_T2CTL, 8'h48);
		wreg(`T2B_ADDR_CAPLO, 8'hf8);
		wreg(`T2B_ADDR_CAPHI, 8'hff);
		wreg(`T2B_ADDR_CNTHI, 8'hff);
		wreg(`T2B_ADDR_CNTLO, 8'hf8);
		wreg(`T2B_ADDR_P0CTL, 8'h40);
		wreg(`T2B_ADDR_T2CTL, 8'h35);
		for (i = 0; i < 60 && rxt[0] !== 1'b1; i = i + 1)
			@(posedge clk) #1;
		chk(16'h0f02, 8'h01, {7'h0, txt[0]});
		i = 0;
		do
		begin
			@(posedge clk) #1;
			i = i + 1;
		end
		while (rxt[0] !== 1'b1 && i < 60);
		chk(16'h0f03, 8'd16, i[7:0]);
		rchk(`T2B_ADDR_T2CTL, 8'h35);
		chk(16'h0f08, 8'h00, {7'h0, hdx[0]});
		send <= 1'b1;
		sbyte <= 8'ha5;
		@(posedge clk);
		send <= 1'b0;
		rchk(`T2B_ADDR_P0BUF, 8'ha5);
		tally_and_finish;
	end
endmodule
